// [csm_idle_det.sv]
`timescale 1ns/10ps
module csm_idle_det
  import csm_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst, // Async reset, high
  input wire logic ce, // Clock enable
  input wire logic clear, // Restart the count
  input wire logic sample, // Sample point pulse
  input wire logic bit_val, // Bit seen by core
  output logic idle // Bus idle reached
);
  typedef struct packed {logic [3:0] cnt; logic idle;} csm_idle_s;
  csm_idle_s s_ff, nxt_s;

  // Count recessive bits at sample points, dominant restarts
  always_comb
  begin
    nxt_s = s_ff;
    if (clear)
      nxt_s.cnt = 4'h0;
    else if (sample && !bit_val)
      nxt_s.cnt = 4'h0;
    else if (sample && s_ff.cnt != CSM_IDLE_BITS)
      nxt_s.cnt = s_ff.cnt + 4'h1;
    nxt_s.idle = (nxt_s.cnt == CSM_IDLE_BITS);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s_ff <= '0;
    else if (ce)
      s_ff <= nxt_s;
  end

  assign idle = s_ff.idle;
endmodule : csm_idle_det

// [csm_pkg.sv]
package csm_pkg;
  localparam logic [7:0] CSM_OFF_CTRL = 8'h00;
  localparam logic [7:0] CSM_OFF_STAT = 8'h04;
  localparam logic [7:0] CSM_OFF_TEST = 8'h08;
  localparam logic [7:0] CSM_OFF_FDC = 8'h0c;
  localparam logic [7:0] CSM_OFF_ERRC = 8'h10;
  localparam logic [7:0] CSM_OFF_AREQ = 8'h14;
  localparam logic [7:0] CSM_OFF_ADAT = 8'h18;
  localparam logic [7:0] CSM_OFF_BREQ = 8'h1c;
  localparam logic [7:0] CSM_OFF_BCTL = 8'h20;
  localparam logic [7:0] CSM_OFF_BDAT = 8'h24;
  localparam logic [7:0] CSM_OFF_MSG = 8'h28;
  localparam int CSM_CTRL_INIT = 0;
  localparam int CSM_CTRL_SS = 5;
  localparam int CSM_CTRL_CCE = 6;
  localparam int CSM_CTRL_TEST = 7;
  localparam int CSM_TEST_BUF = 2;
  localparam int CSM_TEST_SIL = 3;
  localparam int CSM_TEST_LB = 4;
  localparam int CSM_TEST_SEL_LO = 5;
  localparam int CSM_TEST_SEL_HI = 6;
  localparam int CSM_TEST_RX = 7;
  localparam int CSM_FDC_RESTRICT = 0;
  localparam int CSM_REQ_BUSY = 15;
  localparam int CSM_MSG_SEND = 0;
  localparam int CSM_MSG_FRESH = 1;
  localparam int CSM_BCTL_LOSS = 14;
  localparam int CSM_BCTL_FRESH = 15;
  localparam int CSM_ERRC_REC_LSB = 8;
  localparam int CSM_STAT_ACTIVE = 0;
  localparam int CSM_STAT_IDLE = 1;
  localparam int CSM_STAT_LOCK = 2;
  localparam int CSM_STAT_LOG = 3;
  localparam logic [1:0] CSM_DRV_SERIAL = 2'h0;
  localparam logic [1:0] CSM_DRV_SAMPLE = 2'h1;
  localparam logic [1:0] CSM_DRV_LOW = 2'h2;
  localparam logic [1:0] CSM_DRV_HIGH = 2'h3;
  localparam logic [3:0] CSM_IDLE_BITS = 4'hb;
  localparam logic [7:0] CSM_TEC_STEP = 8'h08;
  localparam logic [7:0] CSM_REC_STEP = 8'h01;
  localparam logic [7:0] CSM_CNT_MAX = 8'hff;
  localparam logic [31:0] CSM_ZERO32 = 32'h0000_0000;
  typedef enum logic [1:0] {J_HALT, J_WAIT, J_ACTIVE} csm_join_e;
  typedef enum logic {B_IDLE, B_SEND} csm_btx_e;
endpackage : csm_pkg

// [csm_sync.sv]
`timescale 1ns/10ps
module csm_sync
  import csm_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst, // Async reset, high
  input wire logic ce, // Clock enable
  input wire logic din, // Asynchronous pin level
  output logic dout // Synchronised level
);
  typedef struct packed {logic meta; logic sync;} csm_sync_s;
  csm_sync_s s_ff, nxt_s;

  // Meta stage feeds only the second stage
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.meta = din;
    nxt_s.sync = s_ff.meta;
  end

  // Reset to recessive so the core sees an idle bus
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s_ff <= '{meta: 1'b1, sync: 1'b1};
    else if (ce)
      s_ff <= nxt_s;
  end

  assign dout = s_ff.sync;
endmodule : csm_sync

// [csm_top.sv]
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/10ps
module csm_top
  import csm_pkg::*;
(
  input wire logic clock, // 20 MHz system clock
  input wire logic rst, // Async reset, high
  input wire logic ce, // Clock enable, freezes all state
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  input wire logic can_rx_pin, // Receive pin from transceiver
  output logic can_tx_pin, // Transmit pin to transceiver
  input wire logic core_tx, // Serial bit from core
  input wire logic core_sample_pt, // Sample point pulse
  input wire logic core_tx_start, // Core started a frame
  input wire logic core_tx_ok, // Frame sent successfully
  input wire logic core_tx_fail, // Lost arbitration or error
  input wire logic core_rx_done, // Valid frame received
  input wire logic core_ack_err, // Raw acknowledge error
  input wire logic core_err_cond, // Error or overload seen
  input wire logic core_tx_err, // Transmit error event
  input wire logic core_rx_err, // Receive error event
  input wire logic [31:0] core_rx_word, // Shift register view
  input wire logic [3:0] core_rx_dlc, // Received length
  input wire logic error_log_active_flag, // Error logging busy
  input wire logic [7:0] error_log_count, // Logged error count
  output logic core_rx, // Bit fed to core receiver
  output logic core_tx_req, // Request to transmit
  output logic [31:0] core_tx_word, // Buffer A contents
  output logic core_buf_load, // Load buffer A, pulse
  output logic core_flag_en, // Dominant flags allowed
  output logic core_retry_en, // Retransmission allowed
  output logic core_ack_err_flag, // Acknowledge error to report
  output logic core_bus_active, // Joined bus activity
  output logic tx_done, // Successful send, pulse
  output logic host_wait_n // Host wait, low active
);
  typedef struct packed {
    logic init;
    logic cce;
    logic single_shot_enable;
    logic test;
    logic restricted_mode_enable;
    logic loopback_enable;
    logic silent;
    logic buf_only;
    logic pin_drive_sel_hi;
    logic pin_drive_sel_lo;
    logic send_request_flag;
    logic fresh_content_flag;
    logic a_busy;
    logic a_abort;
    logic [31:0] a_data;
    logic b_fresh;
    logic overwrite_loss_flag;
    logic [3:0] b_dlc;
    logic [31:0] b_data;
    logic [7:0] transmit_error_count;
    logic [7:0] inbound_error_tally;
    csm_join_e join_st;
    csm_btx_e btx;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic core_rx;
    logic tx_pin;
    logic tx_req;
    logic buf_load;
    logic flag_en;
    logic retry_en;
    logic ack_err;
    logic bus_active;
    logic tx_done;
    logic wait_n;
  } csm_state_s;

  csm_state_s s_ff, nxt_s;
  logic rx_s;
  logic bus_idle;
  logic setup;
  logic wr;
  logic log_on;
  logic permit;
  logic [31:0] rd;
  logic rd_err;

  // Pin level crosses in from outside the clock domain
  csm_sync u_sync (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .din(can_rx_pin),
    .dout(rx_s)
  );

  // Idle detector restarts while halted so join waits afresh
  csm_idle_det u_idle (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .clear(s_ff.init),
    .sample(core_sample_pt),
    .bit_val(s_ff.core_rx),
    .idle(bus_idle)
  );

  // Bus phase decode
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && s_ff.pready;
  assign log_on = error_log_active_flag || (error_log_count != 8'h00);
  assign permit = (s_ff.join_st == J_ACTIVE) && !s_ff.init &&
                  !s_ff.restricted_mode_enable && !s_ff.silent;

  // Read mux; unmapped addresses read zero with an error
  always_comb
  begin
    rd = CSM_ZERO32;
    rd_err = 1'b0;
    if (paddr == CSM_OFF_CTRL)
    begin
      rd[CSM_CTRL_INIT] = s_ff.init;
      rd[CSM_CTRL_SS] = s_ff.single_shot_enable;
      rd[CSM_CTRL_CCE] = s_ff.cce;
      rd[CSM_CTRL_TEST] = s_ff.test;
    end
    else if (paddr == CSM_OFF_STAT)
    begin
      rd[CSM_STAT_ACTIVE] = (s_ff.join_st == J_ACTIVE);
      rd[CSM_STAT_IDLE] = bus_idle;
      rd[CSM_STAT_LOCK] = s_ff.a_busy;
      rd[CSM_STAT_LOG] = log_on;
    end
    else if (paddr == CSM_OFF_TEST)
    begin
      rd[CSM_TEST_BUF] = s_ff.buf_only;
      rd[CSM_TEST_SIL] = s_ff.silent;
      rd[CSM_TEST_LB] = s_ff.loopback_enable;
      rd[CSM_TEST_SEL_LO] = s_ff.pin_drive_sel_lo;
      rd[CSM_TEST_SEL_HI] = s_ff.pin_drive_sel_hi;
      rd[CSM_TEST_RX] = rx_s;
    end
    else if (paddr == CSM_OFF_FDC)
      rd[CSM_FDC_RESTRICT] = s_ff.restricted_mode_enable;
    else if (paddr == CSM_OFF_ERRC)
    begin
      rd[7:0] = s_ff.transmit_error_count;
      rd[CSM_ERRC_REC_LSB +: 8] = s_ff.inbound_error_tally;
    end
    else if (paddr == CSM_OFF_AREQ)
      rd[CSM_REQ_BUSY] = s_ff.a_busy;
    else if (paddr == CSM_OFF_ADAT)
      rd = s_ff.a_data;
    else if (paddr == CSM_OFF_BREQ)
      rd = CSM_ZERO32;
    else if (paddr == CSM_OFF_BCTL)
    begin
      rd[3:0] = s_ff.b_dlc;
      rd[CSM_BCTL_LOSS] = s_ff.overwrite_loss_flag;
      rd[CSM_BCTL_FRESH] = s_ff.b_fresh;
    end
    else if (paddr == CSM_OFF_BDAT)
      rd = s_ff.b_data;
    else if (paddr == CSM_OFF_MSG)
    begin
      rd[CSM_MSG_SEND] = s_ff.send_request_flag;
      rd[CSM_MSG_FRESH] = s_ff.fresh_content_flag;
    end
    else
      rd_err = 1'b1;
  end

  // Next state; host writes first, hardware events after so hardware events win
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.pready = setup;
    nxt_s.pslverr = setup && rd_err;
    if (setup && !pwrite)
      nxt_s.prdata = rd;
    // Control and mode writes
    if (wr && paddr == CSM_OFF_CTRL)
    begin
      nxt_s.init = pwdata[CSM_CTRL_INIT];
      nxt_s.single_shot_enable = pwdata[CSM_CTRL_SS];
      nxt_s.cce = pwdata[CSM_CTRL_CCE];
      nxt_s.test = pwdata[CSM_CTRL_TEST];
    end
    if (wr && paddr == CSM_OFF_FDC && s_ff.cce && s_ff.init)
      nxt_s.restricted_mode_enable = pwdata[CSM_FDC_RESTRICT];
    if (wr && paddr == CSM_OFF_TEST && s_ff.test)
    begin
      nxt_s.buf_only = pwdata[CSM_TEST_BUF];
      nxt_s.silent = pwdata[CSM_TEST_SIL];
      nxt_s.loopback_enable = pwdata[CSM_TEST_LB];
      nxt_s.pin_drive_sel_lo = pwdata[CSM_TEST_SEL_LO];
      nxt_s.pin_drive_sel_hi = pwdata[CSM_TEST_SEL_HI];
    end
    if (!nxt_s.test)
    begin
      nxt_s.buf_only = 1'b0;
      nxt_s.silent = 1'b0;
      nxt_s.loopback_enable = 1'b0;
      nxt_s.pin_drive_sel_lo = 1'b0;
      nxt_s.pin_drive_sel_hi = 1'b0;
    end
    // Message object flags under host control
    if (wr && paddr == CSM_OFF_MSG)
    begin
      nxt_s.send_request_flag = pwdata[CSM_MSG_SEND];
      nxt_s.fresh_content_flag = pwdata[CSM_MSG_FRESH];
    end
    // Buffer A: data locked while busy, busy clear aborts
    if (wr && paddr == CSM_OFF_ADAT && !s_ff.a_busy)
      nxt_s.a_data = pwdata;
    if (wr && paddr == CSM_OFF_AREQ)
    begin
      nxt_s.a_busy = pwdata[CSM_REQ_BUSY];
      if (!pwdata[CSM_REQ_BUSY] && s_ff.a_busy &&
          s_ff.btx == B_SEND)
        nxt_s.a_abort = 1'b1;
    end
    if (wr && paddr == CSM_OFF_BCTL)
    begin
      nxt_s.b_fresh = pwdata[CSM_BCTL_FRESH];
      nxt_s.overwrite_loss_flag = pwdata[CSM_BCTL_LOSS];
    end
    // Bus join: halt, wait for idle, active
    case (s_ff.join_st)
      J_HALT:
        if (!s_ff.init)
          nxt_s.join_st = J_WAIT;
      J_WAIT:
        if (s_ff.init)
          nxt_s.join_st = J_HALT;
        else if (bus_idle)
          nxt_s.join_st = J_ACTIVE;
      default:
        if (s_ff.init)
          nxt_s.join_st = J_HALT;
        else if (s_ff.restricted_mode_enable && core_err_cond)
          nxt_s.join_st = J_WAIT;
    endcase
    // Message object transmit progress outside buffer-only mode
    if (!s_ff.buf_only)
    begin
      if (core_tx_start && s_ff.single_shot_enable)
        nxt_s.send_request_flag = 1'b0;
      if (core_tx_ok)
      begin
        nxt_s.send_request_flag = 1'b0;
        nxt_s.fresh_content_flag = 1'b0;
      end
    end
    // Buffer A send sequence
    nxt_s.buf_load = 1'b0;
    case (s_ff.btx)
      B_IDLE:
        if (s_ff.buf_only && s_ff.a_busy && permit && bus_idle)
        begin
          nxt_s.btx = B_SEND;
          nxt_s.buf_load = 1'b1;
        end
      default:
        if (core_tx_ok || !s_ff.buf_only || s_ff.init)
        begin
          nxt_s.btx = B_IDLE;
          nxt_s.a_busy = 1'b0;
          nxt_s.a_abort = 1'b0;
        end
        else if (core_tx_fail)
        begin
          nxt_s.btx = B_IDLE;
          if (s_ff.a_abort || s_ff.single_shot_enable)
            nxt_s.a_busy = 1'b0;
          nxt_s.a_abort = 1'b0;
        end
    endcase
    // Buffer B capture; a second copy while b_fresh is still set marks loss
    if (s_ff.buf_only && (core_rx_done ||
        (wr && paddr == CSM_OFF_BREQ && pwdata[CSM_REQ_BUSY])))
    begin
      nxt_s.b_data = core_rx_word;
      nxt_s.b_dlc = core_rx_dlc;
      nxt_s.overwrite_loss_flag = s_ff.overwrite_loss_flag || s_ff.b_fresh;
      nxt_s.b_fresh = 1'b1;
    end
    // Error counters, saturating, frozen while logging
    if (!log_on)
    begin
      if (core_tx_err)
        nxt_s.transmit_error_count =
          (s_ff.transmit_error_count > CSM_CNT_MAX - CSM_TEC_STEP) ?
          CSM_CNT_MAX : s_ff.transmit_error_count + CSM_TEC_STEP;
      else if (core_tx_ok && s_ff.transmit_error_count != 8'h00)
        nxt_s.transmit_error_count = s_ff.transmit_error_count - 8'h01;
      if (core_rx_err && s_ff.inbound_error_tally != CSM_CNT_MAX)
        nxt_s.inbound_error_tally = s_ff.inbound_error_tally + CSM_REC_STEP;
      else if (core_rx_done && s_ff.inbound_error_tally != 8'h00)
        nxt_s.inbound_error_tally = s_ff.inbound_error_tally - 8'h01;
    end
    // Receive path: loop-back ignores the pin, silent loops dominant
    if (s_ff.loopback_enable)
      nxt_s.core_rx = core_tx;
    else if (s_ff.silent)
      nxt_s.core_rx = rx_s && core_tx;
    else
      nxt_s.core_rx = rx_s;
    // Transmit pin; halt and silent force recessive
    if (s_ff.init || s_ff.silent)
      nxt_s.tx_pin = 1'b1;
    else
      case ({s_ff.pin_drive_sel_hi, s_ff.pin_drive_sel_lo})
        CSM_DRV_SERIAL: nxt_s.tx_pin = core_tx;
        CSM_DRV_SAMPLE: nxt_s.tx_pin = core_sample_pt;
        CSM_DRV_LOW: nxt_s.tx_pin = 1'b0;
        default: nxt_s.tx_pin = 1'b1;
      endcase
    // Core steering
    nxt_s.tx_req = permit && (s_ff.buf_only ? (s_ff.btx == B_SEND) :
                   s_ff.send_request_flag);
    nxt_s.flag_en = !s_ff.restricted_mode_enable && !s_ff.init;
    nxt_s.retry_en = !s_ff.single_shot_enable &&
                     !(s_ff.buf_only && s_ff.a_abort);
    nxt_s.ack_err = core_ack_err && !s_ff.loopback_enable;
    nxt_s.bus_active = (s_ff.join_st == J_ACTIVE) && !s_ff.init;
    nxt_s.tx_done = core_tx_ok;
    // Wait only for request registers in normal mode
    nxt_s.wait_n = !(setup && !s_ff.buf_only &&
                   (paddr == CSM_OFF_AREQ || paddr == CSM_OFF_BREQ));
  end

  // One register for all state; halted and recessive out of reset
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_ff <= '0;
      s_ff.init <= 1'b1;
      s_ff.join_st <= J_HALT;
      s_ff.btx <= B_IDLE;
      s_ff.core_rx <= 1'b1;
      s_ff.tx_pin <= 1'b1;
      s_ff.retry_en <= 1'b1;
      s_ff.wait_n <= 1'b1;
    end
    else if (ce)
      s_ff <= nxt_s;
  end

  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign can_tx_pin = s_ff.tx_pin;
  assign core_rx = s_ff.core_rx;
  assign core_tx_req = s_ff.tx_req;
  assign core_tx_word = s_ff.a_data;
  assign core_buf_load = s_ff.buf_load;
  assign core_flag_en = s_ff.flag_en;
  assign core_retry_en = s_ff.retry_en;
  assign core_ack_err_flag = s_ff.ack_err;
  assign core_bus_active = s_ff.bus_active;
  assign tx_done = s_ff.tx_done;
  assign host_wait_n = s_ff.wait_n;

  // Checks on the mode logic
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_RESTRICT_NO_TX: assert property (
    (ce && s_ff.restricted_mode_enable) |=> !s_ff.tx_req && !s_ff.flag_en)
    else $error("restricted mode allowed a transmission");
  AST_RESTRICT_RESYNC: assert property (
    (ce && s_ff.restricted_mode_enable && s_ff.join_st == J_ACTIVE &&
     !s_ff.init && core_err_cond) |=> s_ff.join_st == J_WAIT)
    else $error("restricted error did not wait for idle");
  AST_ERR_FREEZE: assert property (
    (ce && error_log_active_flag) |=>
    $stable(s_ff.transmit_error_count) && $stable(s_ff.inbound_error_tally))
    else $error("error counter moved during logging");
  AST_FDC_PROTECT: assert property (
    (ce && wr && paddr == CSM_OFF_FDC && !(s_ff.cce && s_ff.init)) |=>
    $stable(s_ff.restricted_mode_enable))
    else $error("restricted enable written without permission");
  AST_SS_START: assert property (
    (ce && s_ff.single_shot_enable && core_tx_start && !core_tx_ok &&
     !s_ff.buf_only && !(wr && paddr == CSM_OFF_MSG)) |=>
    !s_ff.send_request_flag &&
    s_ff.fresh_content_flag == $past(s_ff.fresh_content_flag))
    else $error("single-shot start flags wrong");
  AST_FAIL_KEEPS_FRESH: assert property (
    (ce && core_tx_fail && !core_tx_ok && !(wr && paddr == CSM_OFF_MSG))
    |=> $stable(s_ff.fresh_content_flag))
    else $error("fresh content lost on failed send");
  AST_TEST_OFF: assert property (
    !s_ff.test |-> !s_ff.loopback_enable && !s_ff.silent &&
    !s_ff.buf_only && !s_ff.pin_drive_sel_hi && !s_ff.pin_drive_sel_lo)
    else $error("test bit set while test disabled");
  AST_LB_SILENT: assert property (
    (ce && s_ff.loopback_enable && s_ff.silent) |=>
    s_ff.tx_pin && s_ff.core_rx == $past(core_tx))
    else $error("hot selftest path wrong");
  AST_HALT_PIN: assert property (
    (ce && s_ff.init) |=> s_ff.tx_pin && !s_ff.tx_req)
    else $error("tx pin not recessive while halted");
  AST_ACK_MASK: assert property (
    (ce && s_ff.loopback_enable) |=> !s_ff.ack_err)
    else $error("ack error reported in loop-back");
  AST_BUF_DONE: assert property (
    (ce && s_ff.btx == B_SEND && core_tx_ok &&
     !(wr && paddr == CSM_OFF_AREQ)) |=> !s_ff.a_busy ##1 !s_ff.tx_req)
    else $error("buffer busy not released");
  AST_B_CAPTURE: assert property (
    (ce && s_ff.buf_only && core_rx_done) |=>
    s_ff.b_fresh && s_ff.b_data == $past(core_rx_word))
    else $error("buffer B missed a reception");

  COV_HOT_SELFTEST: cover property (s_ff.loopback_enable && s_ff.silent);
  COV_BUF_LOAD: cover property (s_ff.buf_load);
  COV_SS_START: cover property (s_ff.single_shot_enable && core_tx_start);
  COV_RESTRICT_ERR: cover property (
    s_ff.restricted_mode_enable && core_err_cond);
endmodule : csm_top

// [csm_xcvr.sv]
`timescale 1ns/10ps
module csm_xcvr
(
  input wire logic tx_pin, // Node transmit level
  input wire logic peer_lvl, // Other nodes, low is dominant
  output logic rx_pin // Bus level seen back
);
  // Wired-AND bus, so a dominant level from anyone wins
  assign rx_pin = tx_pin & peer_lvl;
endmodule : csm_xcvr

// [tb_top.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top
  import csm_pkg::*;
;
  logic clock = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic peer_lvl = 1, core_tx = 1, core_sample_pt = 0, core_tx_start = 0;
  logic core_tx_ok = 0, core_tx_fail = 0, core_rx_done = 0, core_ack_err = 0;
  logic core_err_cond = 0, core_tx_err = 0, core_rx_err = 0, er;
  logic error_log_active_flag = 0, pready, pslverr, can_rx_pin, can_tx_pin;
  logic core_rx, core_tx_req, core_buf_load, core_flag_en, core_retry_en;
  logic core_ack_err_flag, core_bus_active, tx_done, host_wait_n;
  logic [7:0] paddr = 8'h00, error_log_count = 8'h00;
  logic [31:0] pwdata = 0, core_rx_word = 0, rd, prdata, core_tx_word;
  logic [3:0] core_rx_dlc = 4'h0;
  logic [1:0] sp = 2'h0;
  int n_fail = 0, compares = 0, i, k;
  csm_top u_csm_top (.*);
  csm_xcvr u_csm_xcvr (.tx_pin(can_tx_pin), .peer_lvl(peer_lvl),
    .rx_pin(can_rx_pin));
  always #25 clock = ~clock;
  // Sample point every fourth cycle, so eight cycles hold exactly two
  always @(posedge clock)
  begin
    sp <= sp + 2'h1;
    core_sample_pt <= (sp == 2'h3);
  end
  // One APB transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Look before the edge; reading after it races the register update
    do
      @(negedge clock);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic end_sim;
    $display("n_fail %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic t_reset;
    `CHK(can_tx_pin, 1'b1)
    `CHK(core_retry_en, 1'b1)
    apb(0, CSM_OFF_CTRL, CSM_ZERO32);
    `CHK(rd[CSM_CTRL_INIT], 1'b1)
    apb(0, CSM_OFF_TEST, CSM_ZERO32);
    `CHK(rd[CSM_TEST_RX], 1'b1)
    apb(0, 8'h40, CSM_ZERO32);
    `CHK({er, rd}, {1'b1, CSM_ZERO32})
  endtask : t_reset
  // Loop-back stays off throughout
  task automatic t_restrict;
    apb(1, CSM_OFF_FDC, 32'h0000_0001);
    apb(0, CSM_OFF_FDC, CSM_ZERO32);
    `CHK(rd[CSM_FDC_RESTRICT], 1'b0)
    apb(1, CSM_OFF_CTRL, 32'h0000_0041);
    apb(1, CSM_OFF_FDC, 32'h0000_0001);
    apb(0, CSM_OFF_FDC, CSM_ZERO32);
    `CHK(rd[CSM_FDC_RESTRICT], 1'b1)
    `CHK({core_flag_en, core_tx_req}, 2'h0)
    apb(1, CSM_OFF_FDC, CSM_ZERO32);
  endtask : t_restrict
  task automatic t_test;
    apb(1, CSM_OFF_TEST, 32'h0000_0018);
    apb(0, CSM_OFF_TEST, CSM_ZERO32);
    `CHK(rd[6:2], 5'h00)
    apb(1, CSM_OFF_CTRL, 32'h0000_00c1);
    apb(1, CSM_OFF_TEST, 32'h0000_0018);
    apb(0, CSM_OFF_TEST, CSM_ZERO32);
    `CHK(rd[6:2], 5'h06)
    apb(1, CSM_OFF_CTRL, 32'h0000_0041);
    apb(0, CSM_OFF_TEST, CSM_ZERO32);
    `CHK(rd[6:2], 5'h00)
  endtask : t_test
  // Modes change only under halt, then halt is left
  task automatic mode(input logic [31:0] t);
    apb(1, CSM_OFF_CTRL, 32'h0000_00c1);
    apb(1, CSM_OFF_TEST, t);
    apb(1, CSM_OFF_CTRL, 32'h0000_0080);
    repeat (4) @(posedge clock);
    @(negedge clock);
  endtask : mode
  task automatic t_loop;
    core_tx <= 1'b0;
    mode(32'h0000_0018);
    `CHK({core_rx, can_tx_pin}, 2'h1)
    mode(32'h0000_0010);
    `CHK({core_rx, can_tx_pin}, 2'h0)
    @(posedge clock);
    core_ack_err <= 1'b1;
    @(posedge clock);
    core_ack_err <= 1'b0;
    @(negedge clock);
    `CHK(core_ack_err_flag, 1'b0)
    core_tx <= 1'b1;
  endtask : t_loop
  task automatic t_drive;
    logic [31:0] code [3];
    int exp [3];
    code = '{32'h0000_0040, 32'h0000_0060, 32'h0000_0020};
    exp = '{0, 8, 2};
    for (k = 0; k < 3; k++)
    begin
      mode(code[k]);
      i = 0;
      repeat (8)
      begin
        @(negedge clock);
        i += int'(can_tx_pin);
      end
      `CHK(i, exp[k])
    end
  endtask : t_drive
  // Pin left in serial function while buffer-only runs
  task automatic t_basic;
    apb(1, CSM_OFF_ADAT, 32'hcafe_0123);
    mode(32'h0000_0004);
    for (i = 0; i < 300 && core_bus_active !== 1'b1; i++)
      @(posedge clock);
    `CHK(core_bus_active, 1'b1)
    @(posedge clock);
    core_tx_err <= 1'b1;
    core_rx_err <= 1'b1;
    @(posedge clock);
    core_rx_err <= 1'b0;
    error_log_active_flag <= 1'b1;
    @(posedge clock);
    core_tx_err <= 1'b0;
    apb(0, CSM_OFF_ERRC, CSM_ZERO32);
    `CHK(rd[15:0], 16'h0108)
    apb(1, CSM_OFF_AREQ, 32'h0000_8000);
    apb(1, CSM_OFF_ADAT, CSM_ZERO32);
    apb(0, CSM_OFF_STAT, CSM_ZERO32);
    `CHK(rd[CSM_STAT_LOCK], 1'b1)
    for (i = 0; i < 300 && core_tx_req !== 1'b1; i++)
      @(posedge clock);
    `CHK(core_tx_req, 1'b1)
    `CHK(core_tx_word, 32'hcafe_0123)
    core_tx_ok <= 1'b1;
    core_rx_word <= 32'h1234_5678;
    core_rx_dlc <= 4'h5;
    core_rx_done <= 1'b1;
    @(posedge clock);
    core_tx_ok <= 1'b0;
    core_rx_done <= 1'b0;
    @(negedge clock);
    `CHK(tx_done, 1'b1)
    apb(0, CSM_OFF_STAT, CSM_ZERO32);
    `CHK(rd[CSM_STAT_LOCK], 1'b0)
    apb(0, CSM_OFF_BDAT, CSM_ZERO32);
    `CHK(rd, 32'h1234_5678)
    apb(0, CSM_OFF_BCTL, CSM_ZERO32);
    `CHK({host_wait_n, rd[15:0]}, 17'h1_8005)
  endtask : t_basic
  // Single shot on the message object; host re-arms after a failure
  task automatic t_shot;
    mode(CSM_ZERO32);
    apb(1, CSM_OFF_CTRL, 32'h0000_0020);
    apb(1, CSM_OFF_MSG, 32'h0000_0003);
    `CHK(core_retry_en, 1'b0)
    core_tx_start <= 1'b1;
    @(posedge clock);
    core_tx_start <= 1'b0;
    apb(0, CSM_OFF_MSG, CSM_ZERO32);
    `CHK(rd[1:0], 2'h2)
    core_tx_fail <= 1'b1;
    @(posedge clock);
    core_tx_fail <= 1'b0;
    apb(0, CSM_OFF_MSG, CSM_ZERO32);
    `CHK(rd[1:0], 2'h2)
    apb(1, CSM_OFF_MSG, 32'h0000_0003);
    core_tx_ok <= 1'b1;
    @(posedge clock);
    core_tx_ok <= 1'b0;
    apb(0, CSM_OFF_MSG, CSM_ZERO32);
    `CHK(rd[1:0], 2'h0)
  endtask : t_shot
  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_restrict;
    t_test;
    t_loop;
    t_drive;
    t_basic;
    t_shot;
    end_sim;
  end
  // Whole run needs a few hundred cycles; cut off far beyond that
  initial
  begin
    #2000000;
    n_fail++;
    end_sim;
  end
endmodule : tb_top
